// >>> hdl/rtu_pkg.sv
// shared constants, field layouts and state records of the rtu support logic
// assumes one 200 MHz processor-side clock and a 32768 Hz time base pin
package rtu_pkg;

  localparam int CLK_HZ         = 200_000_000;
  localparam int RTC_HZ         = 32768;
  localparam int BEAT_HZ        = 32;
  localparam int BEAT_EDGES     = RTC_HZ / BEAT_HZ;
  localparam int BEAT_CNT_W     = 10;
  localparam int WDOG_PULSE_CYC = 16;
  localparam int WAKE_HOLD_CYC  = 8;
  localparam int NV_RESTART_US  = 10;
  localparam int NV_RESTART_CYC = (NV_RESTART_US * (CLK_HZ / 1_000_000));

  // memory map: addr[25:20] picks the region
  localparam logic [5:0] REGION_RAM   = 6'h00;
  localparam logic [5:0] REGION_NVRAM = 6'h01;
  localparam logic [5:0] REGION_FLASH = 6'h3F;
  localparam int         FLASH_DEV_BIT = 19;

  // flash sector bases, byte offsets in the 1 Mbyte flash window
  localparam logic [19:0] SEC_PARAM0_BASE = 20'h04000;
  localparam logic [19:0] SEC_PARAM1_BASE = 20'h08000;
  localparam logic [19:0] SEC_MAIN96_BASE = 20'h0C000;
  localparam logic [19:0] SEC_MAIN1_BASE  = 20'h24000;
  localparam logic [19:0] SEC_MAIN2_BASE  = 20'h44000;
  localparam logic [19:0] SEC_MAIN3_BASE  = 20'h64000;
  localparam logic [19:0] SEC_EXT_BASE    = 20'h84000;

  localparam logic [2:0] SEC_BOOT   = 3'h0;
  localparam logic [2:0] SEC_PARAM0 = 3'h1;
  localparam logic [2:0] SEC_PARAM1 = 3'h2;
  localparam logic [2:0] SEC_MAIN96 = 3'h3;
  localparam logic [2:0] SEC_MAIN1  = 3'h4;
  localparam logic [2:0] SEC_MAIN2  = 3'h5;
  localparam logic [2:0] SEC_MAIN3  = 3'h6;
  localparam logic [2:0] SEC_EXT    = 3'h7;

  // analog mux: six field inputs, then reference and ground
  localparam int         NUM_AIN    = 6;
  localparam logic [2:0] MUX_REF_CH = 3'h6;
  localparam logic [2:0] MUX_GND_CH = 3'h7;

  typedef struct packed {
    logic [25:0] addr;
    logic        rd_n;
    logic        wr_n;
    logic        mem_io;
  } cpu_bus_t;

  typedef struct packed {
    logic       mem_rd_n;
    logic       mem_wr_n;
    logic       io_rd_n;
    logic       io_wr_n;
    logic [1:0] flash_cs_n;
    logic       ram_cs_n;
    logic       nvram_cs_n;
  } mem_strobe_t;

  localparam mem_strobe_t STROBE_IDLE = 8'hFF;

  typedef struct packed {
    logic cfg_change;
    logic power_fail;
  } nv_req_t;

  typedef struct packed {
    logic [7:0] sample_ticks;
    logic [7:0] stab_ticks;
  } adc_cfg_t;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
  } sync_t;

  typedef enum logic [3:0] {
    MX_WAIT  = 4'b0001,
    MX_POWER = 4'b0010,
    MX_START = 4'b0100,
    MX_CONV  = 4'b1000
  } mux_state_t;

  typedef struct packed {
    logic [BEAT_CNT_W-1:0] beat_cnt;
    logic                  hb_irq;
    logic                  clk_on;
    logic [3:0]            wake_hold;
    logic [31:0]           wd_cnt;
    logic [4:0]            rst_cnt;
    logic                  restart;
    logic [11:0]           nv_win;
    logic                  nv_block;
    logic                  boot_block;
    mem_strobe_t           strb;
    logic [31:0]           pcount;
    mux_state_t            mx;
    logic [2:0]            mux_sel;
    logic [7:0]            tick_cnt;
    logic [NUM_AIN-1:0]    pwr;
    logic                  adc_start;
  } top_state_t;

  function automatic logic [2:0] flash_sector(input logic [19:0] off);
    if (off < SEC_PARAM0_BASE) return SEC_BOOT;
    if (off < SEC_PARAM1_BASE) return SEC_PARAM0;
    if (off < SEC_MAIN96_BASE) return SEC_PARAM1;
    if (off < SEC_MAIN1_BASE)  return SEC_MAIN96;
    if (off < SEC_MAIN2_BASE)  return SEC_MAIN1;
    if (off < SEC_MAIN3_BASE)  return SEC_MAIN2;
    if (off < SEC_EXT_BASE)    return SEC_MAIN3;
    return SEC_EXT;
  endfunction

endpackage

// >>> hdl/pin_sync.sv
// three-stage synchroniser for one pin, with a settled level and rise pulse
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import rtu_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.sh   = {s_r.sh[1:0], pin};
    s_nxt.rise = 1'b0;
    // second and third stage must agree before a change counts
    if (s_r.sh[1] == s_r.sh[2] && s_r.sh[2] != s_r.lvl) begin
      s_nxt.lvl  = s_r.sh[2];
      s_nxt.rise = s_r.sh[2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;
  assign rise  = s_r.rise;
endmodule
`default_nettype wire

// >>> hdl/mem_decode.sv
// combinational decode of processor cycles into strobes and chip selects
// assumes the caller registers every output
`timescale 1ns/1ps
`default_nettype none
module mem_decode
  import rtu_pkg::*;
(
  input  wire cpu_bus_t cpu,
  input  wire logic     jumper_fitted,
  input  wire logic     nv_ok,
  output mem_strobe_t   strb,
  output logic          boot_block,
  output logic          nv_block
);
  always_comb begin
    strb       = STROBE_IDLE;
    boot_block = 1'b0;
    nv_block   = 1'b0;
    if (!cpu.mem_io) begin
      strb.io_rd_n = cpu.rd_n;
      strb.io_wr_n = cpu.wr_n;
    end else if (cpu.addr[25:20] == REGION_FLASH) begin
      strb.flash_cs_n[cpu.addr[FLASH_DEV_BIT]] = 1'b0;
      strb.mem_rd_n = cpu.rd_n;
      // erase and program both need a write cycle, so one guard covers them
      if (!cpu.wr_n && flash_sector(cpu.addr[19:0]) == SEC_BOOT && !jumper_fitted) begin
        boot_block = 1'b1;
      end else begin
        strb.mem_wr_n = cpu.wr_n;
      end
    end else if (cpu.addr[25:20] == REGION_RAM) begin
      strb.ram_cs_n = 1'b0;
      strb.mem_rd_n = cpu.rd_n;
      strb.mem_wr_n = cpu.wr_n;
    end else if (cpu.addr[25:20] == REGION_NVRAM) begin
      strb.nvram_cs_n = 1'b0;
      strb.mem_rd_n   = cpu.rd_n;
      if (nv_ok) begin
        strb.mem_wr_n = cpu.wr_n;
      end else begin
        nv_block = !cpu.wr_n;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/rtu_support.sv
// processor support logic: heartbeat, clock gate, watchdog, decode,
// write guards, pulse accumulator and analog mux sequencing
// assumes the processor bus and idle flag are on clk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - raise the heartbeat interrupt 32 times a second from the time base
// - in power-save, stop the processor clock while idle, restart on wake
// - watchdog expiry restarts the processor from its entry point
// - every input pulse increments a counter readable without disturbing it
// - generate memory and io strobes plus one chip select per memory
// - flash decode knows boot, two parameter, one 96K and three 128K sectors
// - boot sector writes blocked unless the protect jumper is fitted
// - nvram writes allowed only on config change, power fail, or for a short window after reset or restart
// - step the analog mux through all channels at a software interval
// - the sequence includes a reference channel and a ground channel
// - in power-save, power the end device and wait before converting
module rtu_support
  import rtu_pkg::*;
#(
  parameter int WDOG_TIMEOUT_MS = 500
)
(
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire cpu_bus_t cpu,
  input  wire logic     cpu_idle,
  input  wire logic     power_save_en,
  input  wire logic     heartbeat_ack,
  input  wire logic     wdog_kick,
  input  wire logic     rtc_clk_pin,
  input  wire logic     pulse_pin,
  input  wire logic     startup_sector_protect_jumper,
  input  wire nv_req_t  nv_req,
  input  wire adc_cfg_t adc_cfg,
  input  wire logic     adc_done,
  output logic          heartbeat_irq,
  output logic          cpu_clk_en,
  output logic          cpu_restart,
  output mem_strobe_t   strobes,
  output logic          boot_write_blocked,
  output logic          nvram_write_blocked,
  output logic [31:0]   pulse_count,
  output logic [2:0]    mux_sel,
  output logic [NUM_AIN-1:0] end_dev_pwr,
  output logic          adc_start
);
  localparam int unsigned WDOG_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);

  top_state_t  st_r;
  top_state_t  st_nxt;
  logic        rtc_rise;
  logic        pulse_rise;
  logic        jumper_fitted;
  logic        tick;
  logic        nv_ok;
  logic        wd_expire;
  mem_strobe_t dec_strb;
  logic        dec_boot_block;
  logic        dec_nv_block;
  logic [7:0]  interval;

  pin_sync u_rtc_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (rtc_clk_pin),
    .level (),
    .rise  (rtc_rise)
  );

  pin_sync u_pulse_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (pulse_pin),
    .level (),
    .rise  (pulse_rise)
  );

  pin_sync u_jumper_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (startup_sector_protect_jumper),
    .level (jumper_fitted),
    .rise  ()
  );

  mem_decode u_decode (
    .cpu           (cpu),
    .jumper_fitted (jumper_fitted),
    .nv_ok         (nv_ok),
    .strb          (dec_strb),
    .boot_block    (dec_boot_block),
    .nv_block      (dec_nv_block)
  );

  assign tick      = rtc_rise && (st_r.beat_cnt == BEAT_CNT_W'(BEAT_EDGES - 1));
  assign nv_ok     = nv_req.cfg_change || nv_req.power_fail || (st_r.nv_win != '0);
  assign wd_expire = !st_r.restart && !wdog_kick && (st_r.wd_cnt == 32'(WDOG_CYC - 1));
  // zero interval would stall the scan, so it counts as one tick
  assign interval  = (adc_cfg.sample_ticks == 8'h00) ? 8'h01 : adc_cfg.sample_ticks;

  always_comb begin
    st_nxt = st_r;

    // heartbeat divider; a new beat wins over an acknowledge in the same cycle
    if (rtc_rise) begin
      st_nxt.beat_cnt = tick ? '0 : st_r.beat_cnt + 1'b1;
    end
    if (tick) begin
      st_nxt.hb_irq = 1'b1;
    end else if (heartbeat_ack) begin
      st_nxt.hb_irq = 1'b0;
    end

    // clock gate; the idle flag lags the wake, so it is ignored briefly
    if (st_r.wake_hold != '0) begin
      st_nxt.wake_hold = st_r.wake_hold - 1'b1;
    end
    // enable kept as a flop of its own so the pin needs no inverter
    if (!power_save_en) begin
      st_nxt.clk_on = 1'b1;
    end else if (tick) begin
      st_nxt.clk_on    = 1'b1;
      st_nxt.wake_hold = 4'(WAKE_HOLD_CYC);
    end else if (st_r.wake_hold == '0 && cpu_idle) begin
      st_nxt.clk_on = 1'b0;
    end

    // watchdog and restart pulse
    if (st_r.restart) begin
      st_nxt.wd_cnt  = '0;
      st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
      if (st_r.rst_cnt == 5'h01) begin
        st_nxt.restart = 1'b0;
        st_nxt.nv_win  = 12'(NV_RESTART_CYC);
      end
    end else if (wdog_kick) begin
      st_nxt.wd_cnt = '0;
    end else if (wd_expire) begin
      st_nxt.wd_cnt  = '0;
      st_nxt.restart = 1'b1;
      st_nxt.rst_cnt = 5'(WDOG_PULSE_CYC);
    end else begin
      st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
    end
    if (st_r.nv_win != '0 && !st_r.restart) begin
      st_nxt.nv_win = st_r.nv_win - 1'b1;
    end

    // decode results registered so every strobe leaves from a flop
    st_nxt.strb       = dec_strb;
    st_nxt.boot_block = dec_boot_block;
    st_nxt.nv_block   = dec_nv_block;

    // free-running count; reads never touch it
    if (pulse_rise) begin
      st_nxt.pcount = st_r.pcount + 1'b1;
    end

    // analog scan
    st_nxt.adc_start = 1'b0;
    if (!power_save_en) begin
      st_nxt.pwr = '1;
    end
    unique case (st_r.mx)
      MX_WAIT: begin
        if (tick) begin
          if (st_r.tick_cnt + 8'h01 >= interval) begin
            st_nxt.tick_cnt = '0;
            if (power_save_en && st_r.mux_sel < 3'(NUM_AIN)) begin
              st_nxt.pwr = NUM_AIN'(1) << st_r.mux_sel;
              st_nxt.mx  = MX_POWER;
            end else begin
              st_nxt.mx = MX_START;
            end
          end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
          end
        end
      end
      MX_POWER: begin
        // settle time counted in heartbeat periods
        if (st_r.tick_cnt >= adc_cfg.stab_ticks) begin
          st_nxt.tick_cnt = '0;
          st_nxt.mx       = MX_START;
        end else if (tick) begin
          st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
        end
      end
      MX_START: begin
        st_nxt.adc_start = 1'b1;
        st_nxt.mx        = MX_CONV;
      end
      MX_CONV: begin
        if (adc_done) begin
          // channels 6 and 7 carry the reference and ground readings
          st_nxt.mux_sel = (st_r.mux_sel == MUX_GND_CH) ? 3'h0 : st_r.mux_sel + 1'b1;
          if (power_save_en) begin
            st_nxt.pwr = '0;
          end
          st_nxt.mx = MX_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.strb   <= STROBE_IDLE;
      st_r.mx     <= MX_WAIT;
      st_r.pwr    <= '1;
      st_r.clk_on <= 1'b1;
      st_r.nv_win <= 12'(NV_RESTART_CYC);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign heartbeat_irq       = st_r.hb_irq;
  assign cpu_clk_en          = st_r.clk_on;
  assign cpu_restart         = st_r.restart;
  assign strobes             = st_r.strb;
  assign boot_write_blocked  = st_r.boot_block;
  assign nvram_write_blocked = st_r.nv_block;
  assign pulse_count         = st_r.pcount;
  assign mux_sel             = st_r.mux_sel;
  assign end_dev_pwr         = st_r.pwr;
  assign adc_start           = st_r.adc_start;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hb_set;
    tick |=> heartbeat_irq;
  endproperty
  a_hb_set: assert property (p_hb_set) else $error("heartbeat not raised");

  property p_hb_div;
    rtc_rise && !tick |=> st_r.beat_cnt == $past(st_r.beat_cnt) + 1'b1;
  endproperty
  a_hb_div: assert property (p_hb_div) else $error("heartbeat divider slipped");

  property p_gate;
    power_save_en && cpu_idle && !tick && st_r.wake_hold == '0 ##1 power_save_en && !tick
      |=> !cpu_clk_en;
  endproperty
  a_gate: assert property (p_gate) else $error("idle clock not gated");

  property p_wake;
    power_save_en && tick |=> cpu_clk_en [*3];
  endproperty
  a_wake: assert property (p_wake) else $error("clock not restored on wake");

  property p_wdog;
    wd_expire |=> cpu_restart [*8] ##8 cpu_restart ##1 !cpu_restart;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog restart pulse wrong");

  property p_pulse;
    pulse_rise |=> pulse_count == $past(pulse_count) + 32'h1;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not counted");

  property p_ram_cs;
    cpu.mem_io && cpu.addr[25:20] == REGION_RAM && !cpu.rd_n
      |=> !strobes.ram_cs_n && !strobes.mem_rd_n && strobes.flash_cs_n == 2'h3;
  endproperty
  a_ram_cs: assert property (p_ram_cs) else $error("ram select missing");

  property p_boot;
    cpu.mem_io && cpu.addr[25:20] == REGION_FLASH && !cpu.wr_n && !jumper_fitted
      && flash_sector(cpu.addr[19:0]) == SEC_BOOT |=> strobes.mem_wr_n && boot_write_blocked;
  endproperty
  a_boot: assert property (p_boot) else $error("boot sector write passed");

  property p_nv;
    cpu.mem_io && cpu.addr[25:20] == REGION_NVRAM && !cpu.wr_n
      |=> strobes.mem_wr_n == !$past(nv_ok) && nvram_write_blocked == !$past(nv_ok);
  endproperty
  a_nv: assert property (p_nv) else $error("nvram guard wrong");

  property p_mux_step;
    st_r.mx == MX_CONV && adc_done && mux_sel != MUX_GND_CH
      |=> mux_sel == $past(mux_sel) + 3'h1 && !adc_start;
  endproperty
  a_mux_step: assert property (p_mux_step) else $error("mux did not step");

  property p_mux_wrap;
    st_r.mx == MX_CONV && adc_done && mux_sel == MUX_GND_CH |=> mux_sel == 3'h0;
  endproperty
  a_mux_wrap: assert property (p_mux_wrap) else $error("mux skipped calibration");

  property p_stab;
    st_r.mx == MX_POWER |-> end_dev_pwr[mux_sel] && !adc_start;
  endproperty
  a_stab: assert property (p_stab) else $error("device unpowered while settling");

endmodule
`default_nettype wire

// >>> tb/host_model.sv
// host processor model: takes heartbeats, kicks the watchdog, then idles
// assumes it acts on the falling edge of clk and only while its clock runs
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic heartbeat_irq,
  input  wire logic cpu_clk_en,
  output var  logic cpu_idle,
  output var  logic heartbeat_ack,
  output var  logic wdog_kick
);
  logic [3:0] busy;

  initial begin
    {cpu_idle, heartbeat_ack, wdog_kick} = 3'h0;
    busy = 4'h0;
  end

  // a gated processor does nothing at all, so no kindness while stopped
  always @(negedge clk) begin
    heartbeat_ack <= 1'b0;
    wdog_kick <= 1'b0;
    if (rst || !run) begin
      cpu_idle <= 1'b0;
      busy <= 4'h0;
    end else if (cpu_clk_en) begin
      if (heartbeat_irq && busy == 4'h0) begin
        heartbeat_ack <= 1'b1;
        wdog_kick <= 1'b1;
        cpu_idle <= 1'b0;
        busy <= 4'hC;
      end else if (busy != 4'h0) begin
        busy <= busy - 4'h1;
      end else begin
        cpu_idle <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/rtu_support_bench.sv
// self-checking bench for rtu_support with the host model on its far side
// assumes 200 MHz clk; time base pin sped up to 8 clk per period
`timescale 1ns/1ps
`default_nettype none
module rtu_support_bench
  import rtu_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        run = 1'b0;
  cpu_bus_t    cpu = {26'h0, 3'h7};
  logic        power_save_en = 1'b0;
  logic        rtc_clk_pin = 1'b0;
  logic        pulse_pin = 1'b0;
  logic        startup_sector_protect_jumper = 1'b0;
  nv_req_t     nv_req = 2'h0;
  adc_cfg_t    adc_cfg = 16'h0100;
  logic        adc_done = 1'b0;
  logic        cpu_idle, heartbeat_ack, wdog_kick;
  logic        heartbeat_irq, cpu_clk_en, cpu_restart, adc_start;
  logic        boot_write_blocked, nvram_write_blocked;
  mem_strobe_t strobes;
  logic [31:0] pulse_count;
  logic [2:0]  mux_sel;
  logic [5:0]  end_dev_pwr;
  logic [2:0]  rc = 3'h0;
  int          rtc_edges = 0;
  int          fail_count = 0;
  int          check_count = 0;

  rtu_support #(.WDOG_TIMEOUT_MS(1)) DUT (
    .clk(clk), .rst(rst), .cpu(cpu), .cpu_idle(cpu_idle),
    .power_save_en(power_save_en), .heartbeat_ack(heartbeat_ack),
    .wdog_kick(wdog_kick), .rtc_clk_pin(rtc_clk_pin), .pulse_pin(pulse_pin),
    .startup_sector_protect_jumper(startup_sector_protect_jumper),
    .nv_req(nv_req), .adc_cfg(adc_cfg), .adc_done(adc_done),
    .heartbeat_irq(heartbeat_irq), .cpu_clk_en(cpu_clk_en),
    .cpu_restart(cpu_restart), .strobes(strobes),
    .boot_write_blocked(boot_write_blocked),
    .nvram_write_blocked(nvram_write_blocked), .pulse_count(pulse_count),
    .mux_sel(mux_sel), .end_dev_pwr(end_dev_pwr), .adc_start(adc_start));

  host_model HOST (
    .clk(clk), .rst(rst), .run(run), .heartbeat_irq(heartbeat_irq),
    .cpu_clk_en(cpu_clk_en), .cpu_idle(cpu_idle),
    .heartbeat_ack(heartbeat_ack), .wdog_kick(wdog_kick));

  always #2.5 clk = ~clk;

  // time base held low in reset so the synchroniser sees no stray edge
  always @(negedge clk) begin
    if (rst) begin
      rc <= 3'h0;
      rtc_clk_pin <= 1'b0;
    end else begin
      rc <= rc + 3'h1;
      rtc_clk_pin <= rc[2];
      if (rc == 3'h4) rtc_edges <= rtc_edges + 1;
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wait_sig(ref logic s, input logic v, input int lim, output int t);
    t = 0;
    while (s !== v && t < lim) begin
      @(negedge clk);
      t++;
    end
  endtask

  // one bus cycle; strobes and flags land one cycle after the request
  task acc(input logic [25:0] a, input logic [2:0] rwm, input logic [7:0] es,
           input logic eb, input logic en);
    @(negedge clk);
    cpu = {a, rwm};
    @(negedge clk);
    check("strobes", strobes, es);
    check("boot_blk", boot_write_blocked, eb);
    check("nv_blk", nvram_write_blocked, en);
    cpu = {26'h0, 3'h7};
  endtask

  task t_mem;
    acc(26'h0100000, 3'h5, 8'hBE, 1'h0, 1'h0);
    acc(26'h0000010, 3'h3, 8'h7D, 1'h0, 1'h0);
    acc(26'h0000010, 3'h2, 8'hDF, 1'h0, 1'h0);
    acc(26'h0000010, 3'h4, 8'hEF, 1'h0, 1'h0);
    acc(26'h0200000, 3'h3, 8'hFF, 1'h0, 1'h0);
    acc(26'h3F80000, 3'h3, 8'h77, 1'h0, 1'h0);
    acc(26'h3F03FFF, 3'h5, 8'hFB, 1'h1, 1'h0);
    acc(26'h3F04000, 3'h5, 8'hBB, 1'h0, 1'h0);
    repeat (2000) @(negedge clk);
    acc(26'h0100000, 3'h5, 8'hFE, 1'h0, 1'h1);
    nv_req = 2'h2;
    acc(26'h0100000, 3'h5, 8'hBE, 1'h0, 1'h0);
    nv_req = 2'h1;
    acc(26'h0100000, 3'h5, 8'hBE, 1'h0, 1'h0);
    nv_req = 2'h0;
    startup_sector_protect_jumper = 1'b1;
    repeat (6) @(negedge clk);
    acc(26'h3F00000, 3'h5, 8'hBB, 1'h0, 1'h0);
    startup_sector_protect_jumper = 1'b0;
  endtask

  task t_pulse;
    for (int i = 1; i <= 5; i++) begin
      pulse_pin = 1'b1;
      repeat (4) @(negedge clk);
      pulse_pin = 1'b0;
      repeat (6) @(negedge clk);
      check("pulse_count", pulse_count, i);
    end
  endtask

  task t_beat;
    int t;
    wait_sig(heartbeat_irq, 1'b1, 9000, t);
    check("irq", heartbeat_irq, 1'h1);
    check("rtc_edges", rtc_edges, 1024);
    repeat (20) @(negedge clk);
    check("irq held", heartbeat_irq, 1'h1);
    run = 1'b1;
    wait_sig(heartbeat_irq, 1'b0, 6, t);
    check("irq ack", heartbeat_irq, 1'h0);
  endtask

  task t_gate;
    int t;
    power_save_en = 1'b1;
    wait_sig(cpu_clk_en, 1'b0, 40, t);
    check("gated", cpu_clk_en, 1'h0);
    wait_sig(heartbeat_irq, 1'b1, 9000, t);
    check("woken", cpu_clk_en, 1'h1);
    wait_sig(cpu_clk_en, 1'b0, 40, t);
    check("regated", cpu_clk_en, 1'h0);
  endtask

  // mux sat on channel 0 since reset, no conversion was ever answered
  task t_scan;
    int t;
    power_save_en = 1'b0;
    check("mux first", mux_sel, 3'h0);
    for (int i = 1; i <= 8; i++) begin
      repeat (2) @(negedge clk);
      adc_done = 1'b1;
      @(negedge clk);
      adc_done = 1'b0;
      wait_sig(adc_start, 1'b1, 9000, t);
      check("adc_start", adc_start, 1'h1);
      check("mux_sel", mux_sel, i % 8);
      check("pwr all", end_dev_pwr, 6'h3F);
    end
  endtask

  // interval 2 and settle 2 heartbeats: each wait spans about two beats
  task t_ps;
    int t;
    power_save_en = 1'b1;
    adc_cfg = 16'h0202;
    repeat (2) @(negedge clk);
    adc_done = 1'b1;
    @(negedge clk);
    adc_done = 1'b0;
    t = 0;
    while (end_dev_pwr !== 6'h02 && t < 20000) begin
      @(negedge clk);
      t++;
    end
    check("pwr one", end_dev_pwr, 6'h02);
    check("interval", t > 12000 && t < 16400, 1'h1);
    wait_sig(adc_start, 1'b1, 20000, t);
    check("settle", t > 12000 && t < 16400, 1'h1);
    check("mux ps", mux_sel, 3'h1);
  endtask

  task t_wdog;
    int t;
    power_save_en = 1'b0;
    run = 1'b0;
    wait_sig(cpu_restart, 1'b1, 210000, t);
    check("restart", cpu_restart, 1'h1);
    check("restart late", t > 191000, 1'h1);
    wait_sig(cpu_restart, 1'b0, 40, t);
    check("restart len", t, 16);
    acc(26'h0100000, 3'h5, 8'hBE, 1'h0, 1'h0);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_mem;
    t_pulse;
    t_beat;
    t_gate;
    t_scan;
    t_ps;
    t_wdog;
    finish_test;
  end

  // whole run is near 320k cycles, dominated by the watchdog timeout
  initial begin
    #2500000;
    fail_count++;
    finish_test;
  end
endmodule
`default_nettype wire
